/* File: system_bus_beat_handshake.sv */
// data tenure handshake: lane parity, beat strobes, termination, bus monitor
`timescale 1ns/1ps
`default_nettype none
`include "beat_handshake_consts.svh"
module system_bus_beat_handshake
  import beat_handshake_pkg::*;
#(
  parameter logic [15:0] TIMEOUT = `MONITOR_TIMEOUT
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // internal request: start a tenure
  input wire logic start_i,
  input wire logic as_slave_i,
  input wire logic burst_i,
  input wire logic narrow_port_i,
  input wire logic write_i,
  input wire logic [15:0] wdata_i,
  // bus pins, upper two lanes
  input wire logic [15:0] data_in_i,
  output logic [15:0] data_out_o,
  output logic data_oe_o,
  input wire logic lane6_parity_i,
  input wire logic lane7_parity_i,
  output logic lane6_parity_o,
  output logic lane7_parity_o,
  output logic parity_oe_o,
  input wire logic beat_termination_ack_b_i,
  input wire logic transfer_error_ack_b_i,
  input wire logic port_beat_valid_b_i,
  output logic beat_termination_ack_b_o,
  output logic transfer_error_ack_b_o,
  output logic port_beat_valid_b_o,
  output logic ack_oe_o,
  // status
  output logic done_o,
  output logic failed_o,
  output logic parity_error_o
);

  state_type cur;
  state_type next_cur;

  function automatic logic odd_bit(input logic [7:0] d);
    odd_bit = ~(^d);
  endfunction : odd_bit

  logic ta_s;
  logic tea_s;
  logic val_s;
  assign ta_s = ~cur.sync_ta[1];
  assign tea_s = ~cur.sync_tea[1];
  assign val_s = ~cur.sync_val[1];

  // ==========================================================
  // next state
  always_comb
  begin
    next_cur = cur;
    next_cur.sync_ta = {cur.sync_ta[1:0], beat_termination_ack_b_i};
    next_cur.sync_tea = {cur.sync_tea[1:0], transfer_error_ack_b_i};
    next_cur.sync_val = {cur.sync_val[1:0], port_beat_valid_b_i};
    next_cur.done = 1'b0;
    next_cur.failed = 1'b0;
    next_cur.par_err = 1'b0;
    next_cur.beat_ack_b = 1'b1;
    next_cur.error_ack_b = 1'b1;
    next_cur.beat_valid_b = 1'b1;
    unique case (cur.phase)
      st_idle:
      begin
        next_cur.ack_oe = 1'b0;
        next_cur.data_oe = 1'b0;
        next_cur.par_oe = 1'b0;
        next_cur.beat_count = 4'h0;
        next_cur.watchdog = 16'h0000;
        if (start_i)
        begin
          if (burst_i)
            next_cur.beat_total = `BURST_BEATS;
          else if (narrow_port_i)
            next_cur.beat_total = `WIDE_PORT_BEATS;
          else
            next_cur.beat_total = 4'h1;
          next_cur.phase = as_slave_i ? st_slave : st_master;
          next_cur.data_oe = write_i ^ as_slave_i;
          next_cur.par_oe = write_i ^ as_slave_i;
          next_cur.ack_oe = as_slave_i;
          next_cur.dout6 = wdata_i[7:0];
          next_cur.dout7 = wdata_i[15:8];
          next_cur.par6 = odd_bit(wdata_i[7:0]);
          next_cur.par7 = odd_bit(wdata_i[15:8]);
        end
      end
      st_slave:
      begin
        // drive one beat per cycle, ack on every beat of a burst, otherwise on the last one only
        next_cur.beat_valid_b = 1'b0;
        next_cur.beat_count = cur.beat_count + 4'h1;
        if (cur.beat_count + 4'h1 == cur.beat_total)
        begin
          next_cur.beat_ack_b = 1'b0;
          next_cur.phase = st_idle;
          next_cur.done = 1'b1;
        end
        else if (cur.beat_total == `BURST_BEATS)
          next_cur.beat_ack_b = 1'b0;
      end
      st_master:
      begin
        next_cur.watchdog = cur.watchdog + 16'h0001;
        if (val_s || ta_s)
        begin
          next_cur.watchdog = 16'h0000;
          if (!cur.data_oe)
          begin
            if (odd_bit(data_in_i[7:0]) != lane6_parity_i
                || odd_bit(data_in_i[15:8]) != lane7_parity_i)
              next_cur.par_err = 1'b1;
          end
          next_cur.beat_count = cur.beat_count + 4'h1;
        end
        if (tea_s)
        begin
          next_cur.phase = st_idle;
          next_cur.failed = 1'b1;
        end
        else if (cur.watchdog >= TIMEOUT)
        begin
          next_cur.error_ack_b = 1'b0;
          next_cur.ack_oe = 1'b1;
          next_cur.phase = st_idle;
          next_cur.failed = 1'b1;
        end
        else if (ta_s && (cur.beat_total == `BURST_BEATS
                 ? cur.beat_count + 4'h1 == `BURST_BEATS : 1'b1))
        begin
          next_cur.phase = st_idle;
          next_cur.done = 1'b1;
        end
      end
      default:
      begin
        next_cur.phase = st_idle;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cur <= '{
        phase: st_idle,
        beat_count: 4'h0,
        beat_total: 4'h1,
        watchdog: 16'h0000,
        beat_ack_b: 1'b1,
        error_ack_b: 1'b1,
        beat_valid_b: 1'b1,
        ack_oe: 1'b0,
        dout6: 8'h00,
        dout7: 8'h00,
        par6: 1'b1,
        par7: 1'b1,
        par_oe: 1'b0,
        data_oe: 1'b0,
        done: 1'b0,
        failed: 1'b0,
        par_err: 1'b0,
        sync_ta: 3'h7,
        sync_tea: 3'h7,
        sync_val: 3'h7
      };
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // ==========================================================
  // outputs
  assign data_out_o = {cur.dout7, cur.dout6};
  assign data_oe_o = cur.data_oe;
  assign lane6_parity_o = cur.par6;
  assign lane7_parity_o = cur.par7;
  assign parity_oe_o = cur.par_oe;
  assign beat_termination_ack_b_o = cur.beat_ack_b;
  assign transfer_error_ack_b_o = cur.error_ack_b;
  assign port_beat_valid_b_o = cur.beat_valid_b;
  assign ack_oe_o = cur.ack_oe;
  assign done_o = cur.done;
  assign failed_o = cur.failed;
  assign parity_error_o = cur.par_err;

endmodule : system_bus_beat_handshake
`default_nettype wire

/* File: beat_handshake_consts.svh */
// constants for the system bus beat handshake block
`ifndef BEAT_HANDSHAKE_CONSTS_SVH
`define BEAT_HANDSHAKE_CONSTS_SVH
`define BURST_BEATS 4'h8
`define WIDE_PORT_BEATS 4'h4
`define MONITOR_TIMEOUT 16'h0100
`define LANE6_LSB 48
`define LANE7_LSB 56
`endif

/* File: beat_handshake_pkg.sv */
// types for the system bus beat handshake block
package beat_handshake_pkg;
  typedef enum logic [1:0]
  {
    st_idle,
    st_slave,
    st_master
  } phase_type;
  typedef struct packed
  {
    phase_type phase;
    logic [3:0] beat_count;
    logic [3:0] beat_total;
    logic [15:0] watchdog;
    logic beat_ack_b;
    logic error_ack_b;
    logic beat_valid_b;
    logic ack_oe;
    logic [7:0] dout6;
    logic [7:0] dout7;
    logic par6;
    logic par7;
    logic par_oe;
    logic data_oe;
    logic done;
    logic failed;
    logic par_err;
    logic [2:0] sync_ta;
    logic [2:0] sync_tea;
    logic [2:0] sync_val;
  } state_type;
endpackage : beat_handshake_pkg

/* File: system_bus_beat_handshake_assertions.sv */
// checker on the beat handshake block ports
`timescale 1ns/1ps
`default_nettype none
module beat_handshake_chk (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [15:0] data_out_o,
  input wire logic lane6_parity_o,
  input wire logic lane7_parity_o,
  input wire logic parity_oe_o,
  input wire logic beat_termination_ack_b_o,
  input wire logic transfer_error_ack_b_o,
  input wire logic port_beat_valid_b_o,
  input wire logic ack_oe_o,
  input wire logic transfer_error_ack_b_i,
  input wire logic done_o,
  input wire logic failed_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence tea_in; $fell(transfer_error_ack_b_i) && !ack_oe_o; endsequence
  chk_par6_odd: assert property (parity_oe_o |-> ^{lane6_parity_o, data_out_o[7:0]})
    else $error("lane6 parity");
  chk_par7_odd: assert property (parity_oe_o |-> ^{lane7_parity_o, data_out_o[15:8]})
    else $error("lane7 parity");
  chk_done_ack: assert property (done_o && ack_oe_o |-> !beat_termination_ack_b_o)
    else $error("no ack");
  chk_tea_fail: assert property (tea_in |-> ##[1:5] failed_o)
    else $error("no fail");
  chk_tea_oe: assert property (!transfer_error_ack_b_o |-> ack_oe_o)
    else $error("tea undriven");
  chk_done_valid: assert property (done_o && ack_oe_o |-> !port_beat_valid_b_o)
    else $error("no valid");
  chk_ack_valid: assert property (!beat_termination_ack_b_o |-> !port_beat_valid_b_o)
    else $error("ack alone");
  chk_valid_oe: assert property (!port_beat_valid_b_o |-> ack_oe_o)
    else $error("valid undriven");
endmodule : beat_handshake_chk
bind system_bus_beat_handshake beat_handshake_chk chk (.*);
`default_nettype wire

/* File: far_slave.sv */
// far side slave model
`timescale 1ns/1ps
`default_nettype none
module far_slave (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [3:0] n_i,
  input wire logic acks_i,
  input wire logic [1:0] fault_i,
  output logic ta_b_o = 1'h1,
  output logic val_b_o = 1'h1,
  output logic tea_b_o = 1'h1,
  output logic [15:0] d_o = 16'h0,
  output logic p6_o = 1'h0,
  output logic p7_o = 1'h0
);
  logic [3:0] left = 4'h0;
  wire logic ok = left != 4'h0 && !fault_i[1];
  always @(posedge clk_i)
  begin
    left <= go_i ? n_i : left - 4'(left != 4'h0);
    val_b_o <= !ok;
    ta_b_o <= !(ok && (acks_i || left == 4'h1));
    tea_b_o <= !(left != 4'h0 && fault_i == 2'h2);
    d_o <= ok ? {left, left, 8'h3C} : ~d_o;
    p6_o <= ok ? 1'h1 ^ fault_i[0] : ~p6_o;
    p7_o <= ok ? 1'h1 ^ fault_i[0] : ~p7_o;
  end
endmodule : far_slave
`default_nettype wire

/* File: tb_system_bus_beat_handshake.sv */
// bench for the beat handshake block
`timescale 1ns/1ps
`default_nettype none
module tb_system_bus_beat_handshake;
  logic clk_i = 1'h0, rst_b_i = 1'h0, start_i = 1'h0, as_slave_i = 1'h0, burst_i = 1'h0;
  logic narrow_port_i = 1'h0, write_i = 1'h0, go = 1'h0, acks = 1'h0, data_oe_o;
  logic lane6_parity_o, lane7_parity_o, parity_oe_o, done_o, failed_o, parity_error_o;
  logic beat_termination_ack_b_o, transfer_error_ack_b_o, port_beat_valid_b_o, ack_oe_o;
  logic m_ta, m_val, m_tea, m_p6, m_p7;
  logic [15:0] wdata_i = 16'h0, data_out_o, m_d;
  logic [3:0] bt = 4'h0, nv = 4'h0, na = 4'h0;
  logic [1:0] flt = 2'h0;
  logic [9:0] notes[$];
  int err_total = 0, checks_done = 0, cycles = 0, k;
  integer seed = 22602;
  always #5 clk_i = ~clk_i;
  system_bus_beat_handshake #(.TIMEOUT(16'h0008)) dut (.*,
    .data_in_i(data_oe_o ? data_out_o : m_d),
    .lane6_parity_i(parity_oe_o ? lane6_parity_o : m_p6),
    .lane7_parity_i(parity_oe_o ? lane7_parity_o : m_p7),
    .beat_termination_ack_b_i(ack_oe_o ? beat_termination_ack_b_o : m_ta),
    .transfer_error_ack_b_i(ack_oe_o ? transfer_error_ack_b_o : m_tea),
    .port_beat_valid_b_i(ack_oe_o ? port_beat_valid_b_o : m_val));
  far_slave model (.clk_i(clk_i), .go_i(go), .n_i(bt), .acks_i(acks), .fault_i(flt),
    .ta_b_o(m_ta), .val_b_o(m_val), .tea_b_o(m_tea), .d_o(m_d), .p6_o(m_p6), .p7_o(m_p7));
  task automatic check(input logic [9:0] seen, exp);
    checks_done++;
    if (seen !== exp)
      err_total++;
    if (seen !== exp)
      $display("BAD %0t got %h want %h", $time, seen, exp);
  endtask : check
  task automatic run(input logic s, b, n, input logic [1:0] f);
    logic [3:0] lb;
    logic w;
    lb = b ? 4'h8 : n ? 4'h4 : 4'h1;
    w = 1'($random(seed));
    notes.push_back({f[1], f == 2'h1 && !w && !s, s ? lb : 4'h0, s ? (b ? lb : 4'h1) : 4'h0});
    @(posedge clk_i);
    {start_i, as_slave_i, burst_i, narrow_port_i, write_i} <= {1'h1, s, b, n, w};
    {go, bt, acks, flt} <= {!s, f == 2'h3 ? 4'h0 : lb, b, f};
    wdata_i <= 16'($random(seed));
    @(posedge clk_i);
    {start_i, go} <= 2'h0;
    @(posedge clk_i);
    check(data_oe_o, w ^ s);
    check(parity_oe_o, w ^ s);
    for (k = 0; k < 60 && !(done_o | failed_o); k++)
      @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    $display("test ended at %0t", $time);
  endtask : run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  always @(posedge clk_i)
    if (rst_b_i)
    begin
      nv = nv + 4'(!port_beat_valid_b_o);
      na = na + 4'(!beat_termination_ack_b_o);
      if (done_o | failed_o)
      begin
        check({failed_o, parity_error_o, nv, na}, notes.pop_front());
        {nv, na} = 8'h00;
      end
    end
  always @(posedge clk_i)
    if (++cycles == 1000)
    begin
      err_total++;
      print_verdict;
    end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'h1;
    run(1'h1, 1'h0, 1'h0, 2'h0);
    run(1'h1, 1'h1, 1'h0, 2'h0);
    run(1'h1, 1'h0, 1'h1, 2'h0);
    run(1'h0, 1'h1, 1'h0, 2'h0);
    run(1'h0, 1'h0, 1'h1, 2'h1);
    run(1'h0, 1'h0, 1'h0, 2'h2);
    run(1'h0, 1'h0, 1'h0, 2'h3);
    check(10'(notes.size()), 10'h000);
    print_verdict;
  end
endmodule : tb_system_bus_beat_handshake
`default_nettype wire
